// ==== dv/crs_exec_model.sv ====
// Purpose: stand-in for instruction execution issuing control ops
// Assumes: requests change only just after falling edges
// Notes: the data field is scrambled between pulses so stale values never look valid
`default_nettype none
module crs_exec_model
    import crs_pkg::*;
(
    input wire logic sys_clk, // core clock
    output crs_ctl_req_t ctl_req, // control instruction pulse
    output logic exc_start // exception start pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ctl_req = '0;
        exc_start = 1'b0;
    end
    // one-cycle control instruction, then idle with inverted data
    task automatic issue(input crs_ctl_op_t op, input crs_target_t tgt, input logic [7:0] d);
        @(negedge sys_clk);
        ctl_req = '{op, tgt, d};
        @(negedge sys_clk);
        ctl_req = '{CRS_OP_NONE, tgt, ~d};
    endtask
    // one-cycle exception start
    task automatic exc();
        @(negedge sys_clk);
        exc_start = 1'b1;
        @(negedge sys_clk);
        exc_start = 1'b0;
    endtask
endmodule // crs_exec_model
`default_nettype wire

// ==== dv/crs_register_set_checker.sv ====
// Purpose: port-level assertions for the core register set
// Assumes: one clock, synchronous reset high
// Notes: ports grouped per line to keep the file short
`default_nettype none
module crs_register_set_checker
    import crs_pkg::*;
(
    input wire logic sys_clk, rst, adv_mode, exc_start, reset_load, pc_wr_en, // controls
    input wire crs_ctl_req_t ctl_req, // control instruction
    input wire logic [23:0] reset_vector, fetch_addr, program_counter, // addresses
    input wire logic [7:0] extended_control, condition_code, // control registers
    input wire logic trace_enable, maskable_blocked, int_holdoff, // status
    input wire logic [2:0] int_mask_level // mask level
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // instructions that start the hold-off
    logic ext_wr;
    assign ext_wr = ctl_req.tgt == CRS_TGT_EXT && ctl_req.op inside {CRS_OP_LOAD, CRS_OP_AND, CRS_OP_OR, CRS_OP_XOR};
    a_rsvd_read_one: assert property (extended_control[6:3] == 4'hf) else $error("reserved bits not one");
    a_ext_field_map: assert property (trace_enable == extended_control[7] &&
        int_mask_level == extended_control[2:0]) else $error("field outputs disagree");
    a_mask_follows_cc: assert property (maskable_blocked == condition_code[7]) else $error("mask bit");
    a_fetch_lsb_zero: assert property (!fetch_addr[0]) else $error("fetch lsb set");
    a_fetch_normal_mask: assert property (!adv_mode [*3] |-> fetch_addr[23:16] == 8'h00)
        else $error("normal fetch above 64k");
    a_exc_sets_mask: assert property (exc_start ##1 ctl_req.op == CRS_OP_NONE |=> condition_code[7])
        else $error("exception left mask clear");
    a_holdoff_cause: assert property ($rose(int_holdoff) |-> $past(ext_wr, 2)) else $error("hold-off cause");
    a_holdoff_len: assert property ($rose(int_holdoff) |-> int_holdoff [*3]) else $error("hold-off short");
    a_reset_values: assert property (@(posedge sys_clk) disable iff (1'b0) rst ##1 rst |=>
        extended_control == 8'h7f && maskable_blocked && !int_holdoff) else $error("reset values");
    a_reset_load_vec: assert property (reset_load && ctl_req.op == CRS_OP_NONE ##1 !pc_wr_en &&
        ctl_req.op == CRS_OP_NONE |=> program_counter == $past(reset_vector, 2) && !trace_enable &&
        int_mask_level == 3'h7) else $error("reset load");
    c_holdoff: cover property ($rose(int_holdoff));
    c_exc: cover property (exc_start);
    c_reset_load: cover property (reset_load);
endmodule // crs_register_set_checker
bind crs_register_set crs_register_set_checker chk_u (.*);
`default_nettype wire

// ==== dv/crs_register_set_tb.sv ====
// Purpose: self-checking bench for the core register set
// Assumes: control ops come from crs_exec_model, one every eight cycles in the op sweep
// Notes: flag_upd is driven once per size, add and subtract, while ctl_req is idle
`default_nettype none
module crs_register_set_tb;
    import crs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic adv_mode = 1'b1;
    logic sp_wr_en = 1'b0, pc_wr_en = 1'b0, reset_load = 1'b0, mac_wr_en = 1'b0, exc_start;
    logic gpr_rd_upper = 1'b0, trace_enable, maskable_blocked, int_holdoff;
    logic [2:0] gpr_rd_idx = '0, int_mask_level;
    logic [7:0] extended_control, condition_code, ctl_store_data, d, cc_m, ext_m = 8'h7f;
    logic [23:0] pc_wr_data = '0, reset_vector = '0, program_counter, fetch_addr;
    logic [31:0] sp_wr_data = '0, gpr_rd_data, stack_pointer, v, gm [8];
    logic [63:0] mac_wr_data = '0, multiply_accumulate_reg;
    crs_size_t gpr_rd_size = CRS_SZ_LONG;
    crs_gpr_wr_t gpr_wr = '0;
    crs_flag_upd_t flag_upd = '0;
    crs_ctl_req_t ctl_req;
    crs_ctl_op_t op;
    int bad_count = 0, checks_done = 0, cycles = 0, seed = 53991, n;
    longint fm;
    logic [3:0] fz;
    crs_register_set dut_u (.*);
    crs_exec_model px (.sys_clk(sys_clk), .ctl_req(ctl_req), .exc_start(exc_start));
    always #4 sys_clk = ~sys_clk;
    // cut a hang short
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 5000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic step(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    task automatic gwr(input int r, input crs_size_t s, input logic up, input logic [31:0] x);
        @(negedge sys_clk);
        gpr_wr = '{1'b1, r[2:0], s, up, x};
        @(negedge sys_clk);
        gpr_wr.en = 1'b0;
    endtask
    function automatic logic [7:0] op_res(input crs_ctl_op_t o, input logic [7:0] cur, input logic [7:0] x);
        case (o)
            CRS_OP_LOAD: return x;
            CRS_OP_AND: return cur & x;
            CRS_OP_OR: return cur | x;
            CRS_OP_XOR: return cur ^ x;
            default: return cur; // a store leaves the register alone
        endcase
    endfunction
    initial begin
        step(2);
        rst = 1'b0;
        chk(extended_control, 8'h7f);
        chk({trace_enable, maskable_blocked, int_holdoff}, 3'b010);
        // every control op on both targets
        for (int t = 0; t < 2; t++) begin
            for (int k = 0; k < 10; k++) begin
                op = crs_ctl_op_t'(k % 5 + 1);
                d = 8'($random(seed));
                px.issue(op, crs_target_t'(t), d);
                n = 0;
                repeat (6) begin
                    @(negedge sys_clk);
                    if (int_holdoff === 1'b1) n++;
                end
                if (t == 1) begin
                    if (op != CRS_OP_STORE) ext_m = (op_res(op, ext_m, d) & 8'h87) | 8'h78;
                    chk(extended_control, ext_m);
                    chk({trace_enable, int_mask_level}, {ext_m[7], ext_m[2:0]});
                end else begin
                    cc_m = op_res(op, cc_m, d);
                    chk({condition_code, maskable_blocked}, {cc_m, cc_m[7]});
                end
                chk(n, (t == 1 && op != CRS_OP_STORE) ? 3 : 0);
                if (op == CRS_OP_STORE) chk(ctl_store_data, t ? ext_m : cc_m);
            end
        end
        px.issue(CRS_OP_LOAD, CRS_TGT_CC, 8'h40);
        step(2);
        chk(maskable_blocked, 1'b0);
        px.exc();
        step(2);
        cc_m = 8'hc0;
        chk(condition_code, cc_m);
        // arithmetic flag updates of every size, add then subtract
        for (int i = 0; i < 6; i++) begin
            fz = 4'($random(seed));
            fm = (64'h1 << (i % 3 == 0 ? 4 : i % 3 == 1 ? 12 : 28)) - 1;
            @(negedge sys_clk);
            flag_upd = '{1'b1, crs_size_t'(i % 3), $random(seed), $random(seed), i > 2, fz[3], fz[2], fz[1], fz[0]};
            @(negedge sys_clk);
            flag_upd.en = 1'b0;
            cc_m[5] = flag_upd.sub ? ((flag_upd.a & fm) < (flag_upd.b & fm)) :
                (((flag_upd.a & fm) + (flag_upd.b & fm)) > fm);
            cc_m[3:0] = fz;
            step(1);
            chk(condition_code, cc_m);
        end
        // partitioned general register writes and reads
        for (int r = 0; r < 8; r++) begin
            v = $random(seed);
            gwr(r, CRS_SZ_LONG, 1'b0, v);
            gwr(r, CRS_SZ_WORD, 1'b1, ~v);
            gwr(r, CRS_SZ_BYTE, r[0], v + 1);
            gm[r] = {~v[15:0], v[15:0]};
            if (r[0]) gm[r][15:8] = v[7:0] + 8'h01;
            else gm[r][7:0] = v[7:0] + 8'h01;
            for (int q = 0; q < 5; q++) begin
                gpr_rd_idx = r[2:0];
                gpr_rd_size = crs_size_t'(q / 2);
                gpr_rd_upper = q[0];
                step(2);
                chk(gpr_rd_data, (gm[r] >> (q[0] ? (q < 2 ? 8 : 16) : 0)) &
                    (q < 2 ? 32'h0000_00ff : q < 4 ? 32'h0000_ffff : 32'hffff_ffff));
            end
        end
        chk(stack_pointer, gm[7]);
        sp_wr_en = 1'b1;
        sp_wr_data = $random(seed);
        step(1);
        sp_wr_en = 1'b0;
        step(2);
        chk({gpr_rd_data, stack_pointer}, {sp_wr_data, sp_wr_data});
        // odd program counter, both address modes
        pc_wr_en = 1'b1;
        pc_wr_data = 24'($random(seed)) | 24'h80_0001;
        mac_wr_en = 1'b1;
        mac_wr_data = {$random(seed), $random(seed)};
        step(1);
        {pc_wr_en, mac_wr_en} = 2'b00;
        step(2);
        chk(program_counter, pc_wr_data);
        chk(fetch_addr, pc_wr_data & 24'hff_fffe);
        chk(multiply_accumulate_reg, mac_wr_data);
        adv_mode = 1'b0;
        step(3);
        chk(fetch_addr, pc_wr_data & 24'h00_fffe);
        px.issue(CRS_OP_LOAD, CRS_TGT_EXT, 8'h80);
        px.issue(CRS_OP_LOAD, CRS_TGT_CC, 8'h00);
        step(6);
        reset_vector = 24'($random(seed));
        reset_load = 1'b1;
        step(1);
        reset_load = 1'b0;
        step(3);
        chk({program_counter, extended_control, condition_code[7]}, {reset_vector, 8'h7f, 1'b1});
        end_of_test();
    end
endmodule // crs_register_set_tb
`default_nettype wire

// ==== hw/crs_params.svh ====
// Purpose: constants for the core register set
// Assumes: included by the register set module
// Notes: field positions, reset values and hold-off count
`ifndef CRS_PARAMS_SVH
`define CRS_PARAMS_SVH
`define CRS_NUM_GPR 8
`define CRS_SP_INDEX 3'h7
`define CRS_PC_WIDTH 24
`define CRS_NORMAL_ADDR_MASK 24'h00_FFFF
`define CRS_ADV_ADDR_MASK 24'hFF_FFFF
`define CRS_EXT_TRACE_BIT 7
`define CRS_EXT_RSVD_MASK 8'h78
`define CRS_EXT_LEVEL_MASK 8'h07
`define CRS_EXT_RESET 8'h7F
`define CRS_CC_IMASK_BIT 7
`define CRS_CC_USER_BIT 6
`define CRS_CC_HALF_BIT 5
`define CRS_CC_USER2_BIT 4
`define CRS_CC_NEG_BIT 3
`define CRS_CC_ZERO_BIT 2
`define CRS_CC_OVF_BIT 1
`define CRS_CC_CARRY_BIT 0
`define CRS_CC_RESET 8'h80
`define CRS_HOLDOFF_STATES 2'h3
`endif

// ==== hw/crs_pkg.sv ====
// Purpose: types shared by the core register set
// Assumes: crs_params.svh supplies the constants
// Notes: only types live here
`default_nettype none
package crs_pkg;
    // width of a general register access
    typedef enum logic [1:0] {CRS_SZ_BYTE, CRS_SZ_WORD, CRS_SZ_LONG} crs_size_t;
    // which control register an instruction targets
    typedef enum logic {CRS_TGT_CC, CRS_TGT_EXT} crs_target_t;
    // control register instruction kind
    typedef enum logic [2:0] {CRS_OP_NONE, CRS_OP_LOAD, CRS_OP_STORE, CRS_OP_AND, CRS_OP_OR,
        CRS_OP_XOR} crs_ctl_op_t;
    // general register write request
    typedef struct packed {
        logic en;
        logic [2:0] idx;
        crs_size_t size;
        logic upper;   // word: extended half; byte: high byte
        logic [31:0] data;
    } crs_gpr_wr_t;
    // control register instruction
    typedef struct packed {
        crs_ctl_op_t op;
        crs_target_t tgt;
        logic [7:0] data;
    } crs_ctl_req_t;
    // flag update from the arithmetic unit
    typedef struct packed {
        logic en;
        crs_size_t size;
        logic [31:0] a;
        logic [31:0] b;
        logic sub;
        logic neg;
        logic zero;
        logic ovf;
        logic carry;
    } crs_flag_upd_t;
endpackage : crs_pkg
`default_nettype wire

// ==== hw/crs_register_set.sv ====
// Purpose: general and control register set of the core
// Assumes: driven by instruction execution and interrupt control on sys_clk
// Notes: writes of the same register in one cycle resolve by process priority
`include "crs_params.svh"
`default_nettype none

// Notes on behaviour
// - addresses are linear: 64 kbyte in normal mode, 16 Mbyte in advanced
// - eight 32-bit general registers, each read and written at 32, 16 or 8 bits
// - each register splits into extended and base 16-bit halves
// - each base half splits into high and low bytes
// - register seven doubles as stack pointer for calls and exceptions
// - program counter is 24 bits, holding next instruction address
// - fetch address forces program counter bit zero to zero
// - a 64-bit multiply-accumulate register sits among the control registers
// - load/and/or/xor to extended control blocks all interrupts three states
// - extended control bit 7 is trace enable, reset 0
// - extended control bits 6 to 3 always read one
// - extended control bits 2 to 0 are mask level, reset all ones
// - condition code bit 7 masks all interrupts but the non-maskable one
// - exception start forces the condition code mask bit to one
// - condition code bit 6 is a plain user bit without masking effect
// - control ops modify condition code; N Z V C feed branches
// - half-carry from bit 3, 11 or 27 by operand size
// - reset loads vector, clears trace, sets masks; others untouched
module crs_register_set
    import crs_pkg::*;
(
    input wire logic sys_clk,                // core clock
    input wire logic rst,                    // synchronous reset, high
    input wire logic adv_mode,               // 1 advanced, 0 normal addressing
    input wire crs_gpr_wr_t gpr_wr,          // general register write
    input wire logic [2:0] gpr_rd_idx,       // general register read index
    input wire crs_size_t gpr_rd_size,       // read width
    input wire logic gpr_rd_upper,           // read extended half or high byte
    input wire logic sp_wr_en,               // implicit stack pointer write
    input wire logic [31:0] sp_wr_data,      // implicit stack pointer value
    input wire logic pc_wr_en,               // program counter load
    input wire logic [23:0] pc_wr_data,      // program counter value
    input wire logic [23:0] reset_vector,    // vector fetched at reset
    input wire logic reset_load,             // reset exception handling loads vector
    input wire logic mac_wr_en,              // multiply-accumulate write
    input wire logic [63:0] mac_wr_data,     // multiply-accumulate value
    input wire crs_ctl_req_t ctl_req,        // control register instruction
    input wire crs_flag_upd_t flag_upd,      // arithmetic flag update
    input wire logic exc_start,              // exception handling begins
    output logic [31:0] gpr_rd_data,         // general register read data
    output logic [31:0] stack_pointer,       // current stack pointer
    output logic [23:0] program_counter,     // stored program counter
    output logic [23:0] fetch_addr,          // instruction fetch address
    output logic [63:0] multiply_accumulate_reg, // multiply-accumulate value
    output logic [7:0] extended_control,     // extended control read value
    output logic [7:0] condition_code,       // condition code read value
    output logic [7:0] ctl_store_data,       // store-control result
    output logic trace_enable,               // raise trace after each instruction
    output logic [2:0] int_mask_level,       // interrupt mask level
    output logic maskable_blocked,           // maskable interrupts blocked
    output logic int_holdoff                 // all interrupts held off
);

    logic [31:0] gpr_full [`CRS_NUM_GPR];
    logic [7:0] ext_q;
    logic [7:0] cc_q;
    logic [1:0] hold_cnt;
    logic [23:0] pc_q;

    // merge a sized write into an old register value
    function automatic logic [31:0] merge_write(input logic [31:0] old, input crs_gpr_wr_t w);
        logic [31:0] r;
        r = old;
        case (w.size)
            CRS_SZ_LONG: r = w.data;
            CRS_SZ_WORD: begin
                if (w.upper) r[31:16] = w.data[15:0];
                else r[15:0] = w.data[15:0];
            end
            CRS_SZ_BYTE: begin
                if (w.upper) r[15:8] = w.data[7:0];
                else r[7:0] = w.data[7:0];
            end
            default: r = old;
        endcase
        return r;
    endfunction

    // extract a sized view of a register, zero extended
    function automatic logic [31:0] view(input logic [31:0] v, input crs_size_t s, input logic up);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (s)
            CRS_SZ_LONG: r = v;
            CRS_SZ_WORD: r = {16'h0000, up ? v[31:16] : v[15:0]};
            CRS_SZ_BYTE: r = {24'h00_0000, up ? v[15:8] : v[7:0]};
            default: r = v;
        endcase
        return r;
    endfunction

    // apply a control instruction to a byte register
    function automatic logic [7:0] ctl_apply(input logic [7:0] old, input crs_ctl_req_t q);
        logic [7:0] r;
        r = old;
        case (q.op)
            CRS_OP_LOAD: r = q.data;
            CRS_OP_AND: r = old & q.data;
            CRS_OP_OR: r = old | q.data;
            CRS_OP_XOR: r = old ^ q.data;
            default: r = old;
        endcase
        return r;
    endfunction

    // half-carry by operand size
    function automatic logic half_carry(input crs_flag_upd_t f);
        logic [28:0] s;
        logic r;
        s = f.sub ? ({1'b0, f.a[27:0]} - {1'b0, f.b[27:0]}) : ({1'b0, f.a[27:0]} + {1'b0, f.b[27:0]});
        r = 1'b0;
        case (f.size)
            CRS_SZ_BYTE: r = f.sub ? (f.a[3:0] < f.b[3:0]) : (5'(f.a[3:0]) + 5'(f.b[3:0]) > 5'h0F);
            CRS_SZ_WORD: r = f.sub ? (f.a[11:0] < f.b[11:0]) : (13'(f.a[11:0]) + 13'(f.b[11:0]) > 13'h0FFF);
            CRS_SZ_LONG: r = s[28];
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // implicit stack pointer write wins
    // no reset: the registers are left uninitialised on purpose
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < `CRS_NUM_GPR; i++) begin
            if (sp_wr_en && 3'(i) == `CRS_SP_INDEX) gpr_full[i] <= sp_wr_data;
            else if (gpr_wr.en && gpr_wr.idx == 3'(i)) gpr_full[i] <= merge_write(gpr_full[i], gpr_wr);
        end
    end

    always_ff @(posedge sys_clk) begin
        gpr_rd_data <= view(gpr_full[gpr_rd_idx], gpr_rd_size, gpr_rd_upper);
        stack_pointer <= gpr_full[`CRS_SP_INDEX];
    end

    always_ff @(posedge sys_clk) begin
        if (reset_load) pc_q <= reset_vector;
        else if (pc_wr_en) pc_q <= pc_wr_data;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            program_counter <= 24'h00_0000;
            fetch_addr <= 24'h00_0000;
        end else begin
            program_counter <= pc_q;
            fetch_addr <= {pc_q[23:1], 1'b0} & (adv_mode ? `CRS_ADV_ADDR_MASK : `CRS_NORMAL_ADDR_MASK);
        end
    end

    // multiply-accumulate register, content kept by its datapath
    always_ff @(posedge sys_clk) begin
        if (mac_wr_en) multiply_accumulate_reg <= mac_wr_data;
    end

    always_ff @(posedge sys_clk) begin
        if (rst || reset_load) begin
            ext_q <= `CRS_EXT_RESET;
        end else if (ctl_req.tgt == CRS_TGT_EXT) begin
            ext_q <= ctl_apply(ext_q, ctl_req) | `CRS_EXT_RSVD_MASK;
        end
    end

    // three state hold-off after ext writes
    always_ff @(posedge sys_clk) begin
        if (rst) hold_cnt <= 2'h0;
        else if (ctl_req.tgt == CRS_TGT_EXT && ctl_req.op != CRS_OP_NONE && ctl_req.op != CRS_OP_STORE)
            hold_cnt <= `CRS_HOLDOFF_STATES;
        else if (hold_cnt != 2'h0) hold_cnt <= hold_cnt - 2'h1;
    end

    always_ff @(posedge sys_clk) begin
        if (rst || reset_load) begin
            cc_q[`CRS_CC_IMASK_BIT] <= 1'b1;
        end else begin
            // an idle request aimed at cc must not block the arithmetic flags
            if (ctl_req.tgt == CRS_TGT_CC && ctl_req.op != CRS_OP_NONE) cc_q <= ctl_apply(cc_q, ctl_req);
            else if (flag_upd.en) begin
                cc_q[`CRS_CC_HALF_BIT] <= half_carry(flag_upd);
                cc_q[`CRS_CC_NEG_BIT] <= flag_upd.neg;
                cc_q[`CRS_CC_ZERO_BIT] <= flag_upd.zero;
                cc_q[`CRS_CC_OVF_BIT] <= flag_upd.ovf;
                cc_q[`CRS_CC_CARRY_BIT] <= flag_upd.carry;
            end
            if (exc_start) cc_q[`CRS_CC_IMASK_BIT] <= 1'b1;
        end
    end

    // registered views for interrupt control and store instructions
    // reserved bits read one
    // mask bit blocks only maskable sources
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            extended_control <= `CRS_EXT_RESET;
            condition_code <= `CRS_CC_RESET;
            ctl_store_data <= 8'h00;
            trace_enable <= 1'b0;
            int_mask_level <= 3'h7;
            maskable_blocked <= 1'b1;
            int_holdoff <= 1'b0;
        end else begin
            extended_control <= ext_q | `CRS_EXT_RSVD_MASK;
            condition_code <= cc_q;
            if (ctl_req.op == CRS_OP_STORE)
                ctl_store_data <= (ctl_req.tgt == CRS_TGT_EXT) ? (ext_q | `CRS_EXT_RSVD_MASK) : cc_q;
            trace_enable <= ext_q[`CRS_EXT_TRACE_BIT];
            int_mask_level <= ext_q[2:0];
            maskable_blocked <= cc_q[`CRS_CC_IMASK_BIT];
            int_holdoff <= (hold_cnt != 2'h0);
        end
    end

endmodule // crs_register_set
`default_nettype wire
